// ==== design/clkgen_consts.svh ====
`ifndef CLKGEN_CONSTS_SVH
`define CLKGEN_CONSTS_SVH
// register indexes, byte address is four times the index
`define IDX_TUNE 8'h96
`define IDX_STATUS 8'h98
`define IDX_DIVIDER 8'h9c
// tune register fields
`define TUNE_RCSEL_BIT 7
`define TUNE_CLKOUT_EN_BIT 6
`define TUNE_FIELD_W 6
// plain default for factory value
`define TUNE_FACTORY_DEFAULT 8'h20
`define DIVIDER_RESET 8'h00
// nominal source frequencies in kHz
`define RC_NOMINAL_KHZ 7373
`define WDOG_NOMINAL_KHZ 400
`define XTAL_LOW_MIN_KHZ 20
`define XTAL_LOW_MAX_KHZ 100
`define XTAL_MED_MAX_KHZ 4000
`define XTAL_HIGH_MAX_KHZ 18000
`define EXT_MAX_KHZ 18000
`define RESET_PIN_NEEDED_KHZ 12000
`endif

// ==== design/clkgen_pkg.sv ====
package clkgen_pkg;
    // oscillator source choice from configuration
    typedef enum logic [2:0] {
        SRC_XTAL_LOW,
        SRC_XTAL_MED,
        SRC_XTAL_HIGH,
        SRC_RC,
        SRC_WDOG,
        SRC_EXT
    } osc_source_t;
endpackage : clkgen_pkg

// ==== design/system_clock_generation.sv ====
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps
`include "clkgen_consts.svh"
// Overview of operation
// - oscillator clock comes from exactly one selected source.
// - a machine cycle is two cpu clock cycles.
// - peripheral clock runs at half the cpu clock.
// - source choice comes from fixed configuration, not a register.
// - crystal offers low, medium and high frequency ranges.
// - six-bit tuning field written by software is kept in the tune register; no output trims the rc oscillator.
// - tuning register loaded with factory value only on power-on reset.
// - rc oscillator is a selectable source, nominally 7.373 MHz.
// - watchdog oscillator usable as source, nominally 400 kHz.
// - clock output only when crystal unused for system and rtc.
// - clock output driven only while enable bit is set.
// - clock output toggles on every cpu clock tick, so it runs at half the cpu clock.
// - external clock accepted; crystal output pin then free for port use.
module system_clock_generation (
    // system
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic por_rst,
    // configuration
    input wire clkgen_pkg::osc_source_t cfg_source,
    input wire logic [7:0] factory_tune,
    input wire logic rtc_uses_crystal,
    // oscillator sources, already on clk_sys as enables, except ext_pin_level which is a raw pin level synchronised here
    input wire logic xtal_tick,
    input wire logic rc_tick,
    input wire logic wdog_tick,
    input wire logic ext_pin_level,
    // crystal output pin as port
    input wire logic port_out_value,
    input wire logic port_out_drive,
    output logic crystal_out_clock_pin_o,
    output logic crystal_out_clock_pin_oe,
    // derived clocks as enables
    output logic oscillator_clock,
    output logic cpu_clock,
    output logic peripheral_clock,
    output logic machine_cycle,
    output logic reset_pin_required,
    // axi4-lite slave
    input wire logic [9:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    input wire logic [9:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready
);
    import clkgen_pkg::*;

    // ==========================================================
    // external clock pin synchroniser
    logic [2:0] ext_sync;
    logic ext_prev;
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ext_sync <= 3'h0;
            ext_prev <= 1'b0;
        end else begin
            ext_sync <= {ext_sync[1:0], ext_pin_level};
            if (ext_sync[2] == ext_sync[1])
                ext_prev <= ext_sync[2];
        end
    end
    wire ext_rise = (ext_sync[2] == ext_sync[1]) && ext_sync[2] && !ext_prev;

    // ==========================================================
    // source selection
    // configured crystal ranges
    wire is_xtal = (cfg_source == SRC_XTAL_LOW) ||
        (cfg_source == SRC_XTAL_MED) || (cfg_source == SRC_XTAL_HIGH);
    wire osc_tick = is_xtal ? xtal_tick :
        (cfg_source == SRC_RC) ? rc_tick :
        (cfg_source == SRC_WDOG) ? wdog_tick :
        (cfg_source == SRC_EXT) ? ext_rise : 1'b0;
    assign oscillator_clock = osc_tick;
    assign reset_pin_required = (cfg_source == SRC_XTAL_HIGH) ||
        (cfg_source == SRC_EXT);

    // ==========================================================
    // registers
    logic [7:0] tune;
    logic [7:0] divider;
    logic [8:0] div_cnt;
    logic cpu_phase;
    logic clkout_q;
    logic bvalid_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] bresp_q;
    logic [1:0] rresp_q;

    // ==========================================================
    // cpu clock divider
    wire [8:0] div_limit = {divider, 1'b0};
    wire div_done = (divider == 8'h00) || (div_cnt + 9'd1 >= div_limit);
    wire cpu_tick = osc_tick && div_done;
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            div_cnt <= 9'd0;
        end else if (osc_tick) begin
            div_cnt <= div_done ? 9'd0 : div_cnt + 9'd1;
        end
    end
    assign cpu_clock = cpu_tick;

    always_ff @(posedge clk_sys) begin
        if (sys_rst)
            cpu_phase <= 1'b0;
        else if (cpu_tick)
            cpu_phase <= ~cpu_phase;
    end
    assign peripheral_clock = cpu_tick && cpu_phase;
    assign machine_cycle = cpu_tick && cpu_phase;

    logic [1:0] cpu_since_slow;
    always_ff @(posedge clk_sys) begin
        if (sys_rst)
            cpu_since_slow <= 2'h0;
        else if (peripheral_clock)
            cpu_since_slow <= 2'h0;
        else if (cpu_tick && cpu_since_slow != 2'h3)
            cpu_since_slow <= cpu_since_slow + 2'h1;
    end

    // ==========================================================
    // clock output pin
    // output allowed
    wire clkout_allowed = tune[`TUNE_CLKOUT_EN_BIT] && !is_xtal &&
        !rtc_uses_crystal;
    always_ff @(posedge clk_sys) begin
        if (sys_rst)
            clkout_q <= 1'b0;
        else if (!clkout_allowed)
            clkout_q <= 1'b0;
        else if (cpu_tick)
            clkout_q <= ~clkout_q;
    end
    assign crystal_out_clock_pin_o = clkout_allowed ? clkout_q :
        port_out_value;
    assign crystal_out_clock_pin_oe = clkout_allowed ? 1'b1 :
        (!is_xtal && !rtc_uses_crystal && port_out_drive);

    // ==========================================================
    // axi4-lite slave
    wire wr_go = s_awvalid && s_wvalid && !bvalid_q;
    wire rd_go = s_arvalid && !rvalid_q;
    // byte addresses, four times the index
    wire [9:0] addr_tune = {`IDX_TUNE, 2'b00};
    wire [9:0] addr_status = {`IDX_STATUS, 2'b00};
    wire [9:0] addr_divider = {`IDX_DIVIDER, 2'b00};
    wire wr_tune = wr_go && (s_awaddr == addr_tune) && s_wstrb[0];
    wire wr_div = wr_go && (s_awaddr == addr_divider) && s_wstrb[0];
    wire wr_hit = (s_awaddr == addr_tune) || (s_awaddr == addr_divider);
    wire [31:0] status_word = {24'h0, 2'b00, clkout_allowed,
        reset_pin_required, is_xtal, cfg_source};
    wire rd_hit = (s_araddr == addr_tune) ||
        (s_araddr == addr_divider) || (s_araddr == addr_status);
    wire [31:0] rd_word = (s_araddr == addr_tune) ? {24'h0, tune} :
        (s_araddr == addr_divider) ? {24'h0, divider} :
        (s_araddr == addr_status) ? status_word : 32'h0;
    assign s_awready = wr_go;
    assign s_wready = wr_go;
    assign s_arready = rd_go;
    assign s_bvalid = bvalid_q;
    assign s_bresp = bresp_q;
    assign s_rvalid = rvalid_q;
    assign s_rdata = rdata_q;
    assign s_rresp = rresp_q;

    always_ff @(posedge clk_sys) begin
        if (por_rst)
            tune <= factory_tune;
        else if (wr_tune)
            tune <= s_wdata[7:0];
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst)
            divider <= `DIVIDER_RESET;
        else if (wr_div)
            divider <= s_wdata[7:0];
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            bvalid_q <= 1'b0;
            bresp_q <= 2'b00;
        end else if (wr_go) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_hit ? 2'b00 : 2'b10;
        end else if (s_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0;
            rresp_q <= 2'b00;
        end else if (rd_go) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_word;
            rresp_q <= rd_hit ? 2'b00 : 2'b10;
        end else if (s_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // ==========================================================
    // assertions
    property p_one_source;
        @(posedge clk_sys) disable iff (sys_rst)
        (cfg_source == SRC_WDOG) |-> (osc_tick == wdog_tick);
    endproperty
    a_one_source: assert property (p_one_source)
        else $error("oscillator clock not from watchdog source");

    property p_half_rate;
        @(posedge clk_sys) disable iff (sys_rst)
        peripheral_clock |-> cpu_tick && cpu_since_slow == 2'h1;
    endproperty
    a_half_rate: assert property (p_half_rate)
        else $error("peripheral tick not every second cpu tick");

    property p_clkout_gate;
        @(posedge clk_sys) disable iff (sys_rst)
        !clkout_allowed |=> !clkout_q;
    endproperty
    a_clkout_gate: assert property (p_clkout_gate)
        else $error("clock output active while disabled");

    property p_clkout_toggle;
        @(posedge clk_sys) disable iff (sys_rst)
        (clkout_allowed && cpu_tick) ##1 clkout_allowed |->
            clkout_q != $past(clkout_q);
    endproperty
    a_clkout_toggle: assert property (p_clkout_toggle)
        else $error("clock output missed a toggle");

    property p_no_xtal_out;
        @(posedge clk_sys) disable iff (sys_rst)
        (is_xtal || rtc_uses_crystal) |-> !clkout_allowed;
    endproperty
    a_no_xtal_out: assert property (p_no_xtal_out)
        else $error("clock output with crystal in use");

    property p_tune_hold;
        @(posedge clk_sys) disable iff (por_rst)
        sys_rst && !wr_tune |=> $stable(tune);
    endproperty
    a_tune_hold: assert property (p_tune_hold)
        else $error("tune changed by non power-on reset");

    property p_tune_write;
        @(posedge clk_sys) disable iff (por_rst)
        wr_tune |=> tune == $past(s_wdata[7:0]);
    endproperty
    a_tune_write: assert property (p_tune_write)
        else $error("tune write lost");

    property p_port_pin;
        @(posedge clk_sys) disable iff (sys_rst)
        !tune[`TUNE_CLKOUT_EN_BIT] |->
            crystal_out_clock_pin_o == port_out_value;
    endproperty
    a_port_pin: assert property (p_port_pin)
        else $error("pin not acting as port pin");

    property p_no_skip;
        @(posedge clk_sys) disable iff (sys_rst)
        cpu_tick && cpu_since_slow == 2'h1 |-> peripheral_clock;
    endproperty
    a_no_skip: assert property (p_no_skip)
        else $error("peripheral tick skipped");

    property p_machine_cycle;
        @(posedge clk_sys) disable iff (sys_rst)
        cpu_tick && cpu_since_slow == 2'h1 |-> machine_cycle;
    endproperty
    a_machine_cycle: assert property (p_machine_cycle)
        else $error("machine cycle not two cpu cycles");

    property p_rc_source;
        @(posedge clk_sys) disable iff (sys_rst)
        (cfg_source == SRC_RC) |-> (oscillator_clock == rc_tick);
    endproperty
    a_rc_source: assert property (p_rc_source)
        else $error("oscillator clock not from rc source");

    property p_xtal_source;
        @(posedge clk_sys) disable iff (sys_rst)
        (cfg_source inside {SRC_XTAL_LOW, SRC_XTAL_MED, SRC_XTAL_HIGH}) |->
            (oscillator_clock == xtal_tick);
    endproperty
    a_xtal_source: assert property (p_xtal_source)
        else $error("oscillator clock not from crystal source");

    property p_ext_source;
        @(posedge clk_sys) disable iff (sys_rst)
        (cfg_source == SRC_EXT) && oscillator_clock ##1
            (cfg_source == SRC_EXT) |-> !oscillator_clock;
    endproperty
    a_ext_source: assert property (p_ext_source)
        else $error("external clock edge gave more than one tick");

    property p_no_xtal_drive;
        @(posedge clk_sys) disable iff (sys_rst)
        (is_xtal || rtc_uses_crystal) |-> !crystal_out_clock_pin_oe;
    endproperty
    a_no_xtal_drive: assert property (p_no_xtal_drive)
        else $error("crystal output pin driven with crystal in use");

    sequence s_write_taken;
        s_awvalid && s_awready && s_wvalid && s_wready;
    endsequence

    sequence s_read_taken;
        s_arvalid && s_arready;
    endsequence

    property p_write_answer;
        @(posedge clk_sys) disable iff (sys_rst)
        s_write_taken |=> s_bvalid;
    endproperty
    a_write_answer: assert property (p_write_answer)
        else $error("write response missing");

    property p_read_answer;
        @(posedge clk_sys) disable iff (sys_rst)
        s_read_taken |=> s_rvalid;
    endproperty
    a_read_answer: assert property (p_read_answer)
        else $error("read response missing");

    property p_bad_read;
        @(posedge clk_sys) disable iff (sys_rst)
        s_read_taken ##0 !rd_hit |=> (s_rresp == 2'b10);
    endproperty
    a_bad_read: assert property (p_bad_read)
        else $error("unmapped read not refused");
endmodule : system_clock_generation

// ==== verification/osc_source_model.sv ====
`timescale 1ns/1ps
// ==========
// oscillator sources as seen on clk_sys
module osc_source_model #(
    parameter int XTAL_DIV = 6,
    parameter int RC_DIV = 4,
    parameter int WDOG_DIV = 16,
    parameter int EXT_HALF = 8
) (
    // system
    input wire logic clk_sys,
    // source ticks and pin
    output logic xtal_tick,
    output logic rc_tick,
    output logic wdog_tick,
    output logic ext_pin_level
);
    int n = 0;
    always @(posedge clk_sys) begin
        n <= n + 1;
        xtal_tick <= (n % XTAL_DIV) == 0;
        rc_tick <= (n % RC_DIV) == 0;
        wdog_tick <= (n % WDOG_DIV) == 0;
        ext_pin_level <= ((n / EXT_HALF) % 2) == 0;
    end
endmodule : osc_source_model

// ==== verification/test_system_clock_generation.sv ====
`timescale 1ns/1ps
// ==========
// bench for clock generation
module test_system_clock_generation;
    import clkgen_pkg::*;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic por_rst = 1'b1;
    osc_source_t cfg_source = SRC_RC;
    logic [7:0] factory_tune = 8'h2b;
    logic rtc_uses_crystal = 1'b0;
    logic port_out_value = 1'b0;
    logic port_out_drive = 1'b0;
    logic xtal_tick, rc_tick, wdog_tick, ext_pin_level;
    logic pin_o, pin_oe, osc_clk, cpu_clk, per_clk, mc, rpr;
    logic [9:0] s_awaddr = 10'h000;
    logic [9:0] s_araddr = 10'h000;
    logic clr_counts = 1'b0;
    logic [31:0] s_wdata = 32'h0;
    logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0;
    logic s_arvalid = 1'b0, s_rready = 1'b0, pin_q = 1'b0;
    logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
    logic [1:0] s_bresp, s_rresp, resp;
    logic [31:0] s_rdata, rd;
    int failures = 0, total_checks = 0, cycles = 0;
    int c_osc, c_cpu, c_per, c_mc, c_tog, c_oe;
    int per[6] = '{6, 6, 6, 4, 16, 16};
    always #2.5 clk_sys = ~clk_sys;
    osc_source_model osc_u (.clk_sys(clk_sys), .xtal_tick(xtal_tick),
        .rc_tick(rc_tick), .wdog_tick(wdog_tick),
        .ext_pin_level(ext_pin_level));
    system_clock_generation dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .por_rst(por_rst), .cfg_source(cfg_source),
        .factory_tune(factory_tune), .rtc_uses_crystal(rtc_uses_crystal),
        .xtal_tick(xtal_tick), .rc_tick(rc_tick), .wdog_tick(wdog_tick),
        .ext_pin_level(ext_pin_level), .port_out_value(port_out_value),
        .port_out_drive(port_out_drive), .crystal_out_clock_pin_o(pin_o),
        .crystal_out_clock_pin_oe(pin_oe), .oscillator_clock(osc_clk),
        .cpu_clock(cpu_clk), .peripheral_clock(per_clk),
        .machine_cycle(mc), .reset_pin_required(rpr),
        .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
        .s_wdata(s_wdata), .s_wstrb(4'h1), .s_wvalid(s_wvalid),
        .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
        .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
        .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp),
        .s_rvalid(s_rvalid), .s_rready(s_rready));
    // ==========
    // counters and helpers
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        pin_q <= pin_o;
        if (clr_counts) begin
            {c_osc, c_cpu, c_per, c_mc, c_tog, c_oe} <= '0;
        end else begin
            c_osc <= c_osc + osc_clk;
            c_cpu <= c_cpu + cpu_clk;
            c_per <= c_per + per_clk;
            c_mc <= c_mc + mc;
            c_tog <= c_tog + (pin_oe && pin_o != pin_q);
            c_oe <= c_oe + pin_oe;
        end
        if (cycles == 20000) begin
            failures++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("checks=%0d failures=%0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : print_verdict
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    function automatic logic [31:0] near(input int a, input int b);
        return 32'(a >= b - 1 && a <= b + 1);
    endfunction : near
    task automatic measure(input int n);
        @(posedge clk_sys);
        clr_counts <= 1'b1;
        @(posedge clk_sys);
        clr_counts <= 1'b0;
        repeat (n) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask : measure
    task automatic axi_write(input logic [9:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        s_awaddr <= a;
        s_wdata <= d;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_awready) s_awvalid <= 1'b0;
            if (s_wready) s_wvalid <= 1'b0;
        end while (!s_bvalid);
        resp = s_bresp;
        s_bready <= 1'b0;
    endtask : axi_write
    task automatic axi_read(input logic [9:0] a);
        @(posedge clk_sys);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_arready) s_arvalid <= 1'b0;
        end while (!s_rvalid);
        rd = s_rdata;
        resp = s_rresp;
        s_rready <= 1'b0;
    endtask : axi_read
    task automatic pulse_reset(input logic por);
        @(posedge clk_sys);
        sys_rst <= 1'b1;
        por_rst <= por;
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        por_rst <= 1'b0;
    endtask : pulse_reset
    // ==========
    // scenarios
    task automatic test_tune_reset();
        // tune index 0x96 sits at byte address 0x258
        axi_read(10'h258);
        check(rd, {24'h0, factory_tune});
        axi_write(10'h258, 32'h15);
        axi_read(10'h258);
        check(rd, 32'h15);
        pulse_reset(1'b0);
        axi_read(10'h258);
        check(rd, 32'h15);
        factory_tune <= 8'h11;
        pulse_reset(1'b1);
        axi_read(10'h258);
        check(rd, 32'h11);
        axi_write(10'h040, 32'h1);
        check(32'(resp), 32'h2);
        axi_read(10'h258);
        check(rd, 32'h11);
        axi_read(10'h040);
        check(32'(resp), 32'h2);
    endtask : test_tune_reset
    task automatic test_sources();
        for (int i = 0; i < 6; i++) begin
            @(posedge clk_sys);
            cfg_source <= osc_source_t'(3'(i));
            measure(400);
            check(near(c_osc, 400 / per[i]), 32'h1);
            check(32'(rpr), 32'(i == 2 || i == 5));
            axi_read(10'h260);
            check(32'(rd[2:0]), 32'(i));
        end
    endtask : test_sources
    task automatic test_divider();
        @(posedge clk_sys);
        cfg_source <= SRC_RC;
        axi_write(10'h270, 32'h2);
        measure(800);
        check(near(c_cpu, 50), 32'h1);
        check(near(c_per, 25), 32'h1);
        check(near(c_mc, 25), 32'h1);
        axi_write(10'h270, 32'h0);
    endtask : test_divider
    task automatic test_clock_out();
        axi_write(10'h258, 32'h40);
        port_out_drive <= 1'b1;
        measure(400);
        check(32'(c_oe), 32'd400);
        check(near(c_tog, 400 / per[3]), 32'h1);
        @(posedge clk_sys);
        rtc_uses_crystal <= 1'b1;
        measure(40);
        check(32'(c_oe), 32'd0);
        @(posedge clk_sys);
        rtc_uses_crystal <= 1'b0;
        cfg_source <= SRC_XTAL_MED;
        measure(40);
        check(32'(c_oe), 32'd0);
        @(posedge clk_sys);
        cfg_source <= SRC_EXT;
        axi_write(10'h258, 32'h00);
        for (int v = 0; v < 4; v++) begin
            @(posedge clk_sys);
            port_out_value <= v[0];
            port_out_drive <= v[1];
            measure(4);
            check(32'({pin_oe, pin_o & pin_oe}), 32'(v[1] * 3 & v));
        end
    endtask : test_clock_out
    initial begin
        repeat (20) @(posedge clk_sys);
        sys_rst <= 1'b0;
        por_rst <= 1'b0;
        test_tune_reset();
        test_sources();
        test_divider();
        test_clock_out();
        print_verdict();
    end
endmodule : test_system_clock_generation
